// ---- caf_pkg.sv ----
// caf_pkg: register map, field positions and encodings for the acceptance filter block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package caf_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADR_MISC    = 8'h00;
  localparam logic [7:0] ADR_RXERR   = 8'h04;
  localparam logic [7:0] ADR_TXERR   = 8'h08;
  localparam logic [7:0] ADR_CTRL    = 8'h0c;
  localparam logic [7:0] ADR_STAT    = 8'h10;
  localparam logic [7:0] ADR_PAT0    = 8'h20; // pattern bytes 0..7 at 0x20..0x3c
  localparam logic [7:0] ADR_IGN0    = 8'h40; // ignore bytes 0..7 at 0x40..0x5c
  localparam logic [7:0] ADR_BANK_M  = 8'he0; // bank region select bits
  localparam int unsigned NFILT      = 8;
  // field positions
  localparam int unsigned CTRL_MODE_LO = 0; // filter_mode_select [1:0]
  localparam int unsigned CTRL_BUSOFF_RECOVERY_MODE_SELECT    = 2; // busoff_recovery_mode_select
  localparam int unsigned STAT_HIT_LO  = 0; // filter_hit_index [2:0]
  localparam int unsigned STAT_HITV    = 3; // hit index valid
  localparam int unsigned STAT_BUSOFF  = 4; // device held bus-off
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  typedef enum logic [1:0] {
    CAF_MODE_32 = 2'b00,
    CAF_MODE_16 = 2'b01,
    CAF_MODE_8  = 2'b10,
    CAF_MODE_CL = 2'b11
  } caf_mode_t;
endpackage

// ---- caf_match.sv ----
// caf_match: pure combinational identifier match for all filter layouts
// assumes pattern/ignore registers and the identifier are stable in clk domain
`timescale 1ns/1ps
module caf_match
  import caf_pkg::*;
(
  input  wire logic [63:0]     pat_i,
  input  wire logic [63:0]     ign_i,
  input  wire logic [31:0]     id_i,
  input  wire logic            ext_i,
  input  wire caf_pkg::caf_mode_t mode_i,
  output logic                 hit_o,
  output logic [2:0]           idx_o
);
  logic [63:0] bmatch;
  // per-layout bit compares: 32-bit banks see id bytes 0..3,
  // 16-bit filters see id bytes 0..1, 8-bit filters see id byte 0 only
  logic [63:0] m32;
  logic [63:0] m16;
  logic [63:0] m8;
  logic [7:0]  bok;
  logic [7:0]  fhit;

  // per-bit compare masked by the ignore bit
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_bit
      // identifier byte 0 sits in id_i[31:24], msb byte first
      assign m32[g]    = pat_i[g] == id_i[24 - 8*((g/8)%4) + g%8];
      assign m16[g]    = pat_i[g] == id_i[24 - 8*((g/8)%2) + g%8];
      assign m8[g]     = pat_i[g] == id_i[24 + g%8];
      assign bmatch[g] = ign_i[g] | ((mode_i == CAF_MODE_32) ? m32[g] :
                                     (mode_i == CAF_MODE_16) ? m16[g] : m8[g]);
    end
    for (g = 0; g < 8; g++) begin : g_byte
      assign bok[g] = &bmatch[8*g+7:8*g];
    end
  endgenerate

  // layout per mode; standard frames use only bytes 0/1 of each 32-bit bank
  always_comb begin
    fhit = 8'h00;
    case (mode_i)
      CAF_MODE_32: begin
        fhit[0] = bok[0] & bok[1] & (~ext_i | (bok[2] & bok[3]));
        fhit[1] = bok[4] & bok[5] & (~ext_i | (bok[6] & bok[7]));
      end
      CAF_MODE_16: begin
        fhit[0] = bok[0] & bok[1];
        fhit[1] = bok[2] & bok[3];
        fhit[2] = bok[4] & bok[5];
        fhit[3] = bok[6] & bok[7];
      end
      CAF_MODE_8:  fhit = bok;
      CAF_MODE_CL: fhit = 8'h00;
      default:     fhit = 8'h00;
    endcase
  end

  // lowest numbered filter wins
  always_comb begin
    idx_o = 3'h0;
    for (int i = NFILT - 1; i >= 0; i--) begin
      if (fhit[i]) begin
        idx_o = i[2:0];
      end
    end
    hit_o = |fhit;
  end
endmodule

// ---- caf_top.sv ----
// caf_top: acceptance filter registers, bus-off hold flag, error counter views
// assumes a classic wishbone master, and protocol engine signals on clk_i
// What this block does
// - writing one to the hold register clears the hold flag; zero ignored
// - with recovery-on-request, entering bus-off sets the hold flag
// - bus-off is held while the hold flag stays one
// - software clears the flag to request recovery; flag reads zero then
// - receive error count is a read-only register; writes ignored
// - transmit error count is a read-only register; writes ignored
// - every received message lands in the background buffer first
// - cpu is notified only for messages that pass the filter
// - rejected message stays unnotified and is overwritten by the next
// - pattern and ignore bytes are compared with four identifier bytes in 2x32 mode, bytes 0 and 1 in 4x16, byte 0 only in 8x8
// - extended identifiers use all four bytes of a bank
// - standard identifiers use only bytes 0 and 1 of a bank
// - eight pattern and eight ignore bytes, writable only in init mode
// - each pattern bit is compared, then masked by its ignore bit
// - ignore bit zero requires equality; one makes the bit don't-care
// - accept only if every non-ignored bit matches
// - mode select: 2x32, 4x16, 8x8, or closed
// - hit index belongs to the foreground message, updated on its move
`timescale 1ns/1ps
module caf_top
  import caf_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone classic slave
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [caf_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [caf_pkg::DATA_W-1:0] dat_i,
  output logic [caf_pkg::DATA_W-1:0]     dat_o,
  output logic                           ack_o,
  // mode handshakes from the control block
  input  wire logic                      init_request_i,
  input  wire logic                      init_ack_i,
  input  wire logic                      sleep_request_i,
  input  wire logic                      sleep_ack_i,
  // protocol engine side
  input  wire logic                      busoff_enter_i,
  input  wire logic [7:0]                receive_error_count_i,
  input  wire logic [7:0]                transmit_error_count_i,
  input  wire logic                      rx_done_i,
  input  wire logic [31:0]               rx_id_i,
  input  wire logic                      rx_ext_i,
  input  wire logic                      fifo_ready_i,
  // results
  output logic                           busoff_hold_o,
  output logic                           busoff_recover_o,
  output logic [31:0]                    bg_id_o,
  output logic                           fifo_push_o,
  output logic                           rx_full_o,
  output logic [2:0]                     filter_hit_index_o
);
  import caf_pkg::*;

  logic [7:0]  pat_r [NFILT];
  logic [7:0]  ign_r [NFILT];
  logic [63:0] pat_flat;
  logic [63:0] ign_flat;
  logic [1:0]  mode_r;
  logic        busoff_recovery_mode_select_r;
  logic        busoff_hold_flag_r;
  logic        busoff_r;
  logic        bg_full_r;
  logic        bg_ext_r;
  logic        hit;
  logic [2:0]  idx;
  logic [2:0]  idx_r;
  logic        init_mode;
  logic        wr;
  logic        rd_en;
  logic        bank_pat;
  logic        bank_ign;
  logic [2:0]  bank_sel;
  logic [7:0]  rd_nxt;
  logic        counters_ok;

  assign init_mode   = init_request_i & init_ack_i;
  assign counters_ok = init_mode | (sleep_request_i & sleep_ack_i);
  assign wr          = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign rd_en       = cyc_i & stb_i & ~ack_o;
  assign bank_pat    = (adr_i & ADR_BANK_M) == ADR_PAT0;
  assign bank_ign    = (adr_i & ADR_BANK_M) == ADR_IGN0;
  assign bank_sel    = adr_i[4:2];

  // flatten banks for the matcher, byte 0 lowest
  genvar g;
  generate
    for (g = 0; g < NFILT; g++) begin : g_flat
      assign pat_flat[8*g+7:8*g] = pat_r[g];
      assign ign_flat[8*g+7:8*g] = ign_r[g];
    end
  endgenerate

  // filter register writes are locked outside init mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NFILT; i++) begin
        pat_r[i] <= REG_RST;
        ign_r[i] <= REG_RST;
      end
      mode_r <= CTRL_RST;
      busoff_recovery_mode_select_r <= 1'b0;
    end else if (wr && init_mode) begin
      if (bank_pat) pat_r[bank_sel] <= dat_i[7:0];
      if (bank_ign) ign_r[bank_sel] <= dat_i[7:0];
      if (adr_i == ADR_CTRL) begin
        mode_r <= dat_i[CTRL_MODE_LO +: 2];
        busoff_recovery_mode_select_r <= dat_i[CTRL_BUSOFF_RECOVERY_MODE_SELECT];
      end
    end
  end

  // hold flag: entering bus-off beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busoff_hold_flag_r <= 1'b0;
    end else if (busoff_enter_i && busoff_recovery_mode_select_r) begin
      busoff_hold_flag_r <= 1'b1;
    end else if (wr && adr_i == ADR_MISC && dat_i[0]) begin
      busoff_hold_flag_r <= 1'b0;
    end
  end

  // bus-off state held until software clears the flag with recovery-on-request; automatic mode releases it next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busoff_r         <= 1'b0;
      busoff_recover_o <= 1'b0;
    end else begin
      busoff_recover_o <= 1'b0;
      if (busoff_enter_i) begin
        busoff_r <= 1'b1;
      end else if (busoff_r && busoff_recovery_mode_select_r && !busoff_hold_flag_r) begin
        busoff_r         <= 1'b0;
        busoff_recover_o <= 1'b1;
      end else if (busoff_r && !busoff_recovery_mode_select_r) begin
        busoff_r         <= 1'b0; // automatic recovery: leave bus-off here, one cycle after entry
        busoff_recover_o <= 1'b1;
      end
    end
  end

  caf_match u_match (
    .pat_i  (pat_flat),
    .ign_i  (ign_flat),
    .id_i   (bg_id_o),
    .ext_i  (bg_ext_r),
    .mode_i (caf_mode_t'(mode_r)),
    .hit_o  (hit),
    .idx_o  (idx)
  );

  // background buffer: every message lands here; a new one overwrites
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bg_id_o   <= 32'h0000_0000;
      bg_ext_r  <= 1'b0;
      bg_full_r <= 1'b0;
    end else if (rx_done_i) begin
      bg_id_o   <= rx_id_i;
      bg_ext_r  <= rx_ext_i;
      bg_full_r <= 1'b1;
    end else if (bg_full_r && (!hit || fifo_ready_i)) begin
      bg_full_r <= 1'b0; // rejected ones simply drop, no notice
    end
  end

  // accepted message moves to fifo; hit index tracks the foreground
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_push_o        <= 1'b0;
      rx_full_o          <= 1'b0;
      idx_r              <= 3'h0;
      filter_hit_index_o <= 3'h0;
    end else begin
      fifo_push_o <= 1'b0;
      if (bg_full_r && !rx_done_i && hit && fifo_ready_i) begin
        fifo_push_o        <= 1'b1;
        rx_full_o          <= 1'b1;
        idx_r              <= idx;
        filter_hit_index_o <= idx;
      end else if (wr && adr_i == ADR_STAT && dat_i[STAT_HITV]) begin
        rx_full_o <= 1'b0;
      end
    end
  end

  // read mux; counters are read-only and ignore writes
  always_comb begin
    rd_nxt = 8'h00;
    if (bank_pat) begin
      rd_nxt = pat_r[bank_sel];
    end else if (bank_ign) begin
      rd_nxt = ign_r[bank_sel];
    end else begin
      case (adr_i)
        ADR_MISC:  rd_nxt = {7'h00, busoff_hold_flag_r};
        ADR_RXERR: rd_nxt = receive_error_count_i;
        ADR_TXERR: rd_nxt = transmit_error_count_i;
        ADR_CTRL:  rd_nxt = {5'h00, busoff_recovery_mode_select_r, mode_r};
        ADR_STAT:  rd_nxt = {3'h0, busoff_r, rx_full_o, idx_r};
        default:   rd_nxt = 8'h00;
      endcase
    end
  end

  // one wait-free answer: ack one cycle after request, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= rd_en;
      dat_o <= rd_en ? {24'h000000, rd_nxt} : 32'h0000_0000;
    end
  end

  assign busoff_hold_o = busoff_hold_flag_r;

  a_hold_set: assert property (@(posedge clk_i) disable iff (rst_i)
    busoff_enter_i && busoff_recovery_mode_select_r |=> busoff_hold_flag_r)
    else $error("hold flag not set on bus-off");
  a_hold_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_MISC && dat_i[0] && !busoff_enter_i |=> !busoff_hold_flag_r)
    else $error("hold flag not cleared");
  a_hold_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_MISC && !dat_i[0] |=> $stable(busoff_hold_flag_r) || busoff_hold_flag_r)
    else $error("zero write changed flag");
  a_busoff_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    busoff_r && busoff_hold_flag_r |=> busoff_r)
    else $error("left bus-off while held");
  a_recover_req: assert property (@(posedge clk_i) disable iff (rst_i)
    busoff_r && busoff_recovery_mode_select_r && !busoff_hold_flag_r && !busoff_enter_i |=> busoff_recover_o)
    else $error("no recovery after clear");
  a_filter_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    !init_mode |=> $stable(pat_flat) && $stable(ign_flat))
    else $error("filter written outside init");
  a_closed_none: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r == CAF_MODE_CL |-> !hit)
    else $error("closed filter accepted");
  a_push_hit: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_push_o |-> $past(hit) && rx_full_o && filter_hit_index_o == $past(idx))
    else $error("push without hit");
  a_bg_store: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_done_i |=> bg_id_o == $past(rx_id_i) && bg_full_r)
    else $error("message not stored");
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
endmodule

// ---- caf_engine_model.sv ----
// caf_engine_model: protocol engine stand-in that delivers frames and bus-off events
// assumes the bench calls its tasks from a process that runs on clk_i edges
`timescale 1ns/1ps
module caf_engine_model (
  input  wire logic        clk_i,
  output logic             rx_done_o,
  output logic [31:0]      rx_id_o,
  output logic             rx_ext_o,
  output logic             busoff_enter_o
);
  // quiet lines at time zero
  initial begin
    rx_done_o      = 1'b0;
    rx_id_o        = 32'h0;
    rx_ext_o       = 1'b0;
    busoff_enter_o = 1'b0;
  end
  // id valid only in the done cycle, inverted after so stale values cannot match
  task automatic send_frame(input logic [31:0] id, input logic ext);
    @(posedge clk_i);
    rx_done_o <= 1'b1;
    rx_id_o   <= id;
    rx_ext_o  <= ext;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    rx_id_o   <= ~id;
    rx_ext_o  <= ~ext;
  endtask
  // entry into bus-off is a one-cycle event
  task automatic enter_busoff();
    @(posedge clk_i);
    busoff_enter_o <= 1'b1;
    @(posedge clk_i);
    busoff_enter_o <= 1'b0;
  endtask
endmodule

// ---- caf_top_test.sv ----
// caf_top_test: self-checking bench for the acceptance filter block
// assumes caf_pkg map; reads are checked by a watcher against queued notes
`timescale 1ns/1ps
module caf_top_test;
  import caf_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, init_rq, init_ak, slp_rq, slp_ak;
  logic        hold, recover, push, full, rx_done, rx_ext, bo_enter;
  logic [7:0]  adr, rxerr, txerr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, bg_id, rx_id, v;
  logic [2:0]  hit_idx;
  logic [3:0]  r;
  logic [7:0]  pat [8];
  logic [7:0]  ign [8];
  logic [31:0] exp_q [$];
  logic [2:0]  idx_q [$];
  int          num_errors, compares, seed, cycles, pushes, recovers, p0;

  caf_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .init_request_i(init_rq), .init_ack_i(init_ak), .sleep_request_i(slp_rq),
    .sleep_ack_i(slp_ak), .busoff_enter_i(bo_enter), .receive_error_count_i(rxerr),
    .transmit_error_count_i(txerr), .rx_done_i(rx_done), .rx_id_i(rx_id),
    .rx_ext_i(rx_ext), .fifo_ready_i(1'b1), .busoff_hold_o(hold),
    .busoff_recover_o(recover), .bg_id_o(bg_id), .fifo_push_o(push), .rx_full_o(full),
    .filter_hit_index_o(hit_idx));
  caf_engine_model i_eng (.clk_i(clk_i), .rx_done_o(rx_done), .rx_id_o(rx_id),
    .rx_ext_o(rx_ext), .busoff_enter_o(bo_enter));

  // 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // classic single cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // reference filter: lowest-numbered hit wins, {hit, index}
  function automatic logic [3:0] ref_match(input logic [31:0] id, input logic ext,
                                           input logic [1:0] m);
    int nf, w, nb;
    logic ok;
    if (m == 2'b11) return 4'h0;
    nf = (m == 2'b00) ? 2 : (m == 2'b01) ? 4 : 8;
    w  = 8 / nf;
    nb = (m == 2'b00 && !ext) ? 2 : w;
    for (int f = 0; f < nf; f++) begin
      ok = 1'b1;
      for (int j = 0; j < nb; j++)
        if (((id[31-8*j -: 8] ^ pat[f*w+j]) & ~ign[f*w+j]) != 8'h0) ok = 1'b0;
      if (ok) return {1'b1, 3'(f)};
    end
    return 4'h0;
  endfunction

  task automatic frame(input logic [31:0] id, input logic ext, input logic [1:0] m);
    r  = ref_match(id, ext, m);
    p0 = pushes;
    if (r[3]) idx_q.push_back(r[2:0]);
    i_eng.send_frame(id, ext);
    #1 check("background id", id, bg_id);
    repeat (3) @(posedge clk_i);
    check("push count", 32'(r[3]), 32'(pushes - p0));
  endtask

  // watcher: read data, hit index, event counts and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (ack === 1'b1 && we === 1'b0)
      check("read data", exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead, rdat);
    if (push === 1'b1)
      check("hit index", idx_q.size() > 0 ? 32'(idx_q.pop_front()) : 32'hbad, 32'(hit_idx));
    if (push === 1'b1) pushes++;
    if (recover === 1'b1) recovers++;
    if (cycles > 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    seed = 49;
    {cyc, stb, we, init_rq, init_ak, slp_rq, slp_ak} = '0;
    {adr, rxerr, txerr, wdat} = '0;
    sel   = 4'h1;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ADR_PAT0 + 8'(4*i), 32'h0);
      rd(ADR_IGN0 + 8'(4*i), 32'h0);
    end
    rd(8'h80, 32'h0);
    bus(1'b1, ADR_PAT0, 32'h5a);
    rd(ADR_PAT0, 32'h0);
    $display("test reset_and_refused done");
    // program both banks in init mode, upper data bits are junk
    init_rq <= 1'b1;
    init_ak <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v      = $random(seed);
      pat[i] = v[7:0];
      ign[i] = v[15:8] | v[23:16] | v[31:24];
      if (i % 2 == 1) ign[i] = ign[i] | 8'h07;
      bus(1'b1, ADR_PAT0 + 8'(4*i), {v[31:8], pat[i]});
      bus(1'b1, ADR_IGN0 + 8'(4*i), {v[31:8], ign[i]});
    end
    for (int i = 0; i < 8; i++) begin
      rd(ADR_PAT0 + 8'(4*i), {24'h0, pat[i]});
      rd(ADR_IGN0 + 8'(4*i), {24'h0, ign[i]});
    end
    v = $random(seed);
    rxerr <= v[7:0];
    txerr <= v[15:8];
    bus(1'b1, ADR_RXERR, ~v);
    bus(1'b1, ADR_TXERR, ~v);
    rd(ADR_RXERR, {24'h0, v[7:0]});
    rd(ADR_TXERR, {24'h0, v[15:8]});
    init_rq <= 1'b0;
    init_ak <= 1'b0;
    slp_rq  <= 1'b1;
    slp_ak  <= 1'b1;
    rd(ADR_RXERR, {24'h0, v[7:0]});
    rd(ADR_TXERR, {24'h0, v[15:8]});
    slp_rq <= 1'b0;
    slp_ak <= 1'b0;
    $display("test registers done");
    // every layout, ids alternately random and built from stored patterns
    for (int m = 0; m < 4; m++) begin
      init_rq <= 1'b1;
      init_ak <= 1'b1;
      bus(1'b1, ADR_CTRL, 32'(m));
      init_rq <= 1'b0;
      init_ak <= 1'b0;
      for (int j = 0; j < 12; j++) begin
        v = $random(seed);
        if (j % 2 == 0) v = {pat[j%8], pat[(j+1)%8], pat[(j+2)%8], v[7:0]};
        frame(v, j[1], 2'(m));
      end
    end
    check("rx full set", 32'h1, 32'(full));
    bus(1'b1, ADR_STAT, 32'h8);
    #1 check("rx full cleared", 32'h0, 32'(full));
    $display("test filter done");
    // hold until software clears the flag
    init_rq <= 1'b1;
    init_ak <= 1'b1;
    bus(1'b1, ADR_CTRL, 32'h4);
    init_rq <= 1'b0;
    init_ak <= 1'b0;
    i_eng.enter_busoff();
    #1 check("hold set", 32'h1, 32'(hold));
    rd(ADR_MISC, 32'h1);
    bus(1'b1, ADR_MISC, 32'h0);
    rd(ADR_MISC, 32'h1);
    check("early recovery", 32'h0, 32'(recovers));
    bus(1'b1, ADR_MISC, 32'h1);
    rd(ADR_MISC, 32'h0);
    check("recovery pulses", 32'h1, 32'(recovers));
    $display("test busoff done");
    tally_and_finish();
  end
endmodule
